/* hdl/upb_regs.svh */
/*
  Register offsets, reset values and timing counts of the pushbutton block.
  Assumes inclusion once per compilation unit; the guard handles repeats.
*/
`ifndef UPB_REGS_SVH
`define UPB_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define UPB_OFF_MODE 12'h000
`define UPB_OFF_REPORT 12'h004
`define UPB_OFF_FLASH 12'h008
`define UPB_OFF_STATE 12'h00c
`define UPB_OFF_IRQ_STAT 12'h010
`define UPB_OFF_IRQ_MASK 12'h014
`define UPB_OFF_MSG 12'h018
`define UPB_OFF_DROP 12'h040
`define UPB_OFF_TEXT 12'h800

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define UPB_REPORT_TGT_LSB 16
`define UPB_STATE_OFF_LSB 16
`define UPB_MSG_CH_LSB 4
`define UPB_MSG_KIND_LSB 8
`define UPB_MODE_RST 24'h000000
`define UPB_REPORT_RST 32'h00000000
`define UPB_FLASH_RST 16'h03e8
`define UPB_DROP_RST 16'h0000

// ****************************************************************
// Timing: the time base tick and the debounce window.
// ****************************************************************
`define UPB_CLK_PERIOD_NS 10
`define UPB_TICK_NS 1000000
`define UPB_DEB_SAMPLES 3

`endif

/* hdl/upb_pkg.sv */
/*
  Types shared by the pushbutton block and its text memory.
  Assumes upb_regs.svh is available for the numeric constants.
*/
package upb_pkg;
  // Number of pushbutton channels.
  localparam int UPB_NUM_CH = 12;
  // Characteristic of one channel, as held in its two mode bits.
  typedef enum logic [1:0] {
    UPB_DISABLED = 2'h0,
    UPB_MOMENTARY = 2'h1,
    UPB_LATCHED = 2'h2
  } upb_mode_type;
  // Which stored text line a message refers to.
  typedef enum logic [1:0] {
    UPB_TXT_LABEL = 2'h0,
    UPB_TXT_ACTIVE = 2'h1,
    UPB_TXT_INACTIVE = 2'h2
  } upb_text_type;
  // Word index into the text store: channel, line kind, word.
  typedef logic [8:0] upb_taddr_type;
endpackage

/* hdl/upb_text_if.sv */
/*
  Carrier between the pushbutton core and its text memory.
  Assumes one clock; the core writes, the display side reads.
*/
`timescale 1ns/1ps
interface upb_text_if;
  // Write side, driven by the bus slave.
  logic wrEn;
  upb_pkg::upb_taddr_type wrAddr;
  logic [31:0] wrData;
  // Read side, driven by the display reader.
  upb_pkg::upb_taddr_type rdAddr;
  logic [31:0] rdData;
  // Clock enable that freezes the memory.
  logic ce;
  modport core (output wrEn, wrAddr, wrData, rdAddr, ce, input rdData);
  modport mem (input wrEn, wrAddr, wrData, rdAddr, ce, output rdData);
endinterface

/* hdl/upb_text_mem.sv */
/*
  Text store: label, active and inactive lines of twenty characters
  for every channel, four characters to a word, read data registered.
  Assumes the core drives the carrier; contents are undefined at power-up.
*/
`timescale 1ns/1ps
module upb_text_mem (
  // Clock.
  input wire logic clk,
  // Carrier to the core.
  upb_text_if.mem tif
);
  import upb_pkg::*;

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [31:0] memQ [0:511]; // Word array, no reset by design.
  logic [31:0] rdQ; // Registered read word.

  // Writes and the registered read both stop while ce is low.
  always_ff @(posedge clk) begin
    if (tif.ce) begin
      if (tif.wrEn) begin
        memQ[tif.wrAddr] <= tif.wrData;
      end
      rdQ <= memQ[tif.rdAddr];
    end
  end

  assign tif.rdData = rdQ;
endmodule

/* hdl/upb_top.sv */
/*
  User pushbutton logic: twelve channels with on and off flags, an
  indicator per channel, disabled, momentary and latched characteristics,
  event reporting, message selection and an AHB-Lite register slave.
  Assumes buttons are asynchronous pins and non-volatile storage presents
  the saved latched states on nvLoad while and after reset.
*/
`timescale 1ns/1ps
`include "upb_regs.svh"
module upb_top #(
  // Clock cycles per time base tick; shorten in simulation.
  parameter int TICK_CYCLES = `UPB_TICK_NS / `UPB_CLK_PERIOD_NS
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Buttons and logic flags.
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] btnIn,
  output logic [upb_pkg::UPB_NUM_CH-1:0] chanOn,
  output logic [upb_pkg::UPB_NUM_CH-1:0] chanOff,
  output logic [upb_pkg::UPB_NUM_CH-1:0] chanLed,
  // Non-volatile storage of latched states.
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] nvLoad,
  output logic [upb_pkg::UPB_NUM_CH-1:0] nvData,
  output logic nvWrite,
  // Event recorder.
  output logic evtValid,
  output logic [upb_pkg::UPB_NUM_CH-1:0] evtChange,
  output logic [upb_pkg::UPB_NUM_CH-1:0] evtState,
  // Message selection and text read-out.
  output logic msgActive,
  output logic [3:0] msgChannel,
  output upb_pkg::upb_text_type msgKind,
  input wire upb_pkg::upb_taddr_type textRdAddr,
  output logic [31:0] textRdData,
  // Interrupt.
  output logic irq
);
  import upb_pkg::*;
  localparam int NC = UPB_NUM_CH;

  // ****************************************************************
  // Time base and restore sequencing.
  // ****************************************************************
  logic [31:0] tickCntQ, tickCntD; // Divider toward the tick.
  logic tick; // One-cycle time base pulse.
  logic [1:0] rstSeqQ, rstSeqD; // Counts cycles after reset release.
  logic restore; // Cycle that loads the saved latched states.
  logic [NC-1:0] nvS1Q, nvS2Q; // Synchroniser for the saved states.

  // Tick every TICK_CYCLES enabled cycles.
  always_comb begin
    tick = (tickCntQ == 32'(TICK_CYCLES - 1));
    tickCntD = tick ? 32'h00000000 : tickCntQ + 32'h00000001;
    rstSeqD = (rstSeqQ == 2'h3) ? rstSeqQ : rstSeqQ + 2'h1;
    restore = (rstSeqQ == 2'h2);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tickCntQ <= 32'h00000000;
      rstSeqQ <= 2'h0;
      nvS1Q <= '0;
      nvS2Q <= '0;
    end else if (ce) begin
      tickCntQ <= tickCntD;
      rstSeqQ <= rstSeqD;
      nvS1Q <= nvLoad;
      nvS2Q <= nvS1Q;
    end
  end

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [23:0] modeQ, modeD; // Two mode bits per channel.
  logic [31:0] reportQ, reportD; // Log enables low, message enables high.
  logic [15:0] flashQ, flashD; // Message duration in ticks.
  logic [15:0] dropQ [NC], dropD [NC]; // Drop-out delay per channel, ticks.
  logic [NC-1:0] irqStatQ, irqStatD; // Sticky change flags.
  logic [NC-1:0] irqMaskQ, irqMaskD; // Interrupt enables.
  logic [11:0] dAddrQ; // Data phase byte offset.
  logic dWrQ; // Data phase is a write.
  logic [31:0] rdataQ, rdataD; // Registered read data.
  logic aphase; // Valid address phase this cycle.
  logic wrStb; // Register write in this data phase.

  // ****************************************************************
  // Channel state.
  // ****************************************************************
  logic [NC-1:0] onVecQ, onVecD; // On flags now and next.
  logic [NC-1:0] latVecQ, latVecD; // Latched states now and next.
  logic [NC-1:0] isLatched; // Channel set to latched.
  logic [NC-1:0] isEnabled; // Channel set to momentary or latched.

  for (genvar i = 0; i < NC; i++) begin : gCh
    logic s1Q, s2Q; // Button synchroniser.
    logic [`UPB_DEB_SAMPLES-1:0] histQ, histD; // Tick samples.
    logic debQ, debD; // Debounced button.
    logic [15:0] cntQ, cntD; // Drop-out extension counter.
    logic rise, fall; // Debounced press and release.
    upb_mode_type mode; // This channel's characteristic.

    // Debounce, edge, toggle and drop-out logic of one channel.
    always_comb begin
      mode = upb_mode_type'(modeQ[2*i +: 2]);
      histD = histQ;
      debD = debQ;
      if (tick) begin
        histD = {histQ[`UPB_DEB_SAMPLES-2:0], s2Q};
        if (&histD) begin
          debD = 1'b1;
        end else if (~|histD) begin
          debD = 1'b0;
        end
      end
      rise = debD & ~debQ;
      fall = ~debD & debQ;
      // Latched state: restored once, then toggled on each press while the channel is set to latched.
      latVecD[i] = latVecQ[i];
      if (restore) begin
        latVecD[i] = nvS2Q[i];
      end else if (mode == UPB_LATCHED && rise) begin
        latVecD[i] = ~latVecQ[i];
      end
      // Drop-out extension runs on the tick.
      cntD = cntQ;
      if (mode != UPB_MOMENTARY || debD) begin
        cntD = 16'h0000;
      end else if (fall) begin
        cntD = dropQ[i];
      end else if (tick && cntQ != 16'h0000) begin
        cntD = cntQ - 16'h0001;
      end
      case (mode)
        UPB_MOMENTARY: onVecD[i] = debD | (cntD != 16'h0000);
        UPB_LATCHED: onVecD[i] = latVecD[i];
        default: onVecD[i] = 1'b0;
      endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        s1Q <= 1'b0;
        s2Q <= 1'b0;
        histQ <= '0;
        debQ <= 1'b0;
        cntQ <= 16'h0000;
        onVecQ[i] <= 1'b0;
        latVecQ[i] <= 1'b0;
      end else if (ce) begin
        s1Q <= btnIn[i];
        s2Q <= s1Q;
        histQ <= histD;
        debQ <= debD;
        cntQ <= cntD;
        onVecQ[i] <= onVecD[i];
        latVecQ[i] <= latVecD[i];
      end
    end

    assign isLatched[i] = (mode == UPB_LATCHED);
    assign isEnabled[i] = (mode == UPB_LATCHED) || (mode == UPB_MOMENTARY);
  end

  // On flags and indicators come straight from the on flops; off flags are also gated by isEnabled.
  assign chanOn = onVecQ;
  assign chanOff = ~onVecQ & isEnabled;
  assign chanLed = onVecQ;
  assign nvData = latVecQ;

  // ****************************************************************
  // Events, messages and the interrupt.
  // ****************************************************************
  logic [NC-1:0] chg; // Channels whose on flag changes now.
  logic [NC-1:0] msgReq; // Channels asking for a message.
  logic evtValidQ, evtValidD;
  logic [NC-1:0] evtChangeQ, evtChangeD, evtStateQ, evtStateD;
  logic nvWriteQ, nvWriteD;
  logic msgActQ, msgActD;
  logic [3:0] msgChQ, msgChD;
  upb_text_type msgKindQ, msgKindD;
  logic [15:0] msgTimeQ, msgTimeD; // Ticks left on the shown message.

  // Report changes and pick the lowest requesting channel to show.
  always_comb begin
    chg = onVecD ^ onVecQ;
    evtChangeD = chg & reportQ[NC-1:0];
    evtValidD = |evtChangeD;
    evtStateD = onVecD;
    nvWriteD = |(latVecD ^ latVecQ) && !restore;
    msgReq = (chg & onVecD) | (chg & ~onVecD & isLatched);
    msgReq = msgReq & reportQ[`UPB_REPORT_TGT_LSB +: NC];
    msgActD = msgActQ;
    msgChD = msgChQ;
    msgKindD = msgKindQ;
    msgTimeD = msgTimeQ;
    if (msgActQ && tick) begin
      msgTimeD = msgTimeQ - 16'h0001;
      msgActD = (msgTimeD != 16'h0000);
    end
    for (int c = NC - 1; c >= 0; c--) begin
      if (msgReq[c]) begin
        msgChD = 4'(c);
        msgKindD = onVecD[c] ? UPB_TXT_ACTIVE : UPB_TXT_INACTIVE;
        msgTimeD = flashQ;
        msgActD = (flashQ != 16'h0000);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evtValidQ <= 1'b0;
      evtChangeQ <= '0;
      evtStateQ <= '0;
      nvWriteQ <= 1'b0;
      msgActQ <= 1'b0;
      msgChQ <= 4'h0;
      msgKindQ <= UPB_TXT_LABEL;
      msgTimeQ <= 16'h0000;
    end else if (ce) begin
      evtValidQ <= evtValidD;
      evtChangeQ <= evtChangeD;
      evtStateQ <= evtStateD;
      nvWriteQ <= nvWriteD;
      msgActQ <= msgActD;
      msgChQ <= msgChD;
      msgKindQ <= msgKindD;
      msgTimeQ <= msgTimeD;
    end
  end

  assign evtValid = evtValidQ;
  assign evtChange = evtChangeQ;
  assign evtState = evtStateQ;
  assign nvWrite = nvWriteQ;
  assign msgActive = msgActQ;
  assign msgChannel = msgChQ;
  assign msgKind = msgKindQ;
  assign irq = |(irqStatQ & irqMaskQ);

  // ****************************************************************
  // AHB-Lite slave.
  // ****************************************************************
  // Zero wait states unless the block is frozen; always OKAY.
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = rdataQ;
  assign aphase = hsel && htrans[1] && hready;
  assign wrStb = dWrQ && (dAddrQ < `UPB_OFF_TEXT);

  // Write decode, sticky flags and the read multiplexer.
  always_comb begin
    modeD = modeQ;
    reportD = reportQ;
    flashD = flashQ;
    irqMaskD = irqMaskQ;
    irqStatD = irqStatQ;
    for (int c = 0; c < NC; c++) begin
      dropD[c] = dropQ[c];
    end
    if (wrStb) begin
      case (dAddrQ)
        `UPB_OFF_MODE: modeD = hwdata[23:0];
        `UPB_OFF_REPORT: reportD = hwdata;
        `UPB_OFF_FLASH: flashD = hwdata[15:0];
        `UPB_OFF_IRQ_STAT: irqStatD = irqStatQ & ~hwdata[NC-1:0];
        `UPB_OFF_IRQ_MASK: irqMaskD = hwdata[NC-1:0];
        default: begin
          for (int c = 0; c < NC; c++) begin
            if (dAddrQ == `UPB_OFF_DROP + 12'(4 * c)) begin
              dropD[c] = hwdata[15:0];
            end
          end
        end
      endcase
    end
    irqStatD = irqStatD | chg; // Set wins over clear.
    rdataD = rdataQ;
    if (aphase && !hwrite) begin
      rdataD = 32'h00000000;
      case (haddr[11:0])
        `UPB_OFF_MODE: rdataD = {8'h00, modeQ};
        `UPB_OFF_REPORT: rdataD = reportQ;
        `UPB_OFF_FLASH: rdataD = {16'h0000, flashQ};
        `UPB_OFF_STATE:
          rdataD = {4'h0, chanOff, 4'h0, onVecQ};
        `UPB_OFF_IRQ_STAT: rdataD = {20'h00000, irqStatQ};
        `UPB_OFF_IRQ_MASK: rdataD = {20'h00000, irqMaskQ};
        `UPB_OFF_MSG:
          rdataD = {22'h000000, msgKindQ, msgChQ, 3'h0, msgActQ};
        default: begin
          for (int c = 0; c < NC; c++) begin
            if (haddr[11:0] == `UPB_OFF_DROP + 12'(4 * c)) begin
              rdataD = {16'h0000, dropQ[c]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modeQ <= `UPB_MODE_RST;
      reportQ <= `UPB_REPORT_RST;
      flashQ <= `UPB_FLASH_RST;
      irqStatQ <= '0;
      irqMaskQ <= '0;
      dAddrQ <= 12'h000;
      dWrQ <= 1'b0;
      rdataQ <= 32'h00000000;
      for (int c = 0; c < NC; c++) begin
        dropQ[c] <= `UPB_DROP_RST;
      end
    end else if (ce) begin
      modeQ <= modeD;
      reportQ <= reportD;
      flashQ <= flashD;
      irqStatQ <= irqStatD;
      irqMaskQ <= irqMaskD;
      dAddrQ <= haddr[11:0];
      dWrQ <= aphase && hwrite;
      rdataQ <= rdataD;
      for (int c = 0; c < NC; c++) begin
        dropQ[c] <= dropD[c];
      end
    end
  end

  // ****************************************************************
  // Text store for label, active and inactive lines.
  // ****************************************************************
  upb_text_if tif ();

  assign tif.ce = ce;
  assign tif.wrEn = dWrQ && (dAddrQ >= `UPB_OFF_TEXT);
  assign tif.wrAddr = upb_taddr_type'(dAddrQ[10:2]);
  assign tif.wrData = hwdata;
  assign tif.rdAddr = textRdAddr;
  assign textRdData = tif.rdData;

  upb_text_mem uMem (
    .clk(clk),
    .tif(tif)
  );
endmodule

/* tb/upb_top_chk.sv */
/*
  Port checker of the pushbutton block, bound into every upb_top.
  Assumes one clock, an asynchronous active-low reset, hready = hreadyout.
*/
`timescale 1ns/1ps
module upb_top_chk #(
  // Clock cycles per tick, handed on from the design.
  parameter int TICK_CYCLES = 4
) (
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Flags, storage, events and messages.
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] chanOn,
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] chanOff,
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] chanLed,
  input wire logic nvWrite,
  input wire logic evtValid,
  input wire logic [upb_pkg::UPB_NUM_CH-1:0] evtState,
  input wire logic msgActive,
  input wire logic [3:0] msgChannel,
  input wire upb_pkg::upb_text_type msgKind
);
  import upb_pkg::*;
  // ****************************************************************
  // Sequences.
  // ****************************************************************
  // All checks sample on the rising clock and pause in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A cycle in which the slave takes no read.
  sequence noRead;
    !(hsel && htrans[1] && !hwrite && hready);
  endsequence
  // A pulse that lasts one cycle only.
  sequence onePulse(sig);
    sig ##1 !sig;
  endsequence
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // A channel never shows on and off together.
  off_excl_a: assert property ((chanOn & chanOff) == '0)
    else $error("On and off flags of one channel both high.");
  // The indicator mirrors the on flag, drop-out included.
  led_follow_a: assert property (chanLed == chanOn)
    else $error("Indicator differs from the on flag.");
  // The slave is ready exactly while enabled.
  ready_ce_a: assert property (hreadyout == ce)
    else $error("Ready does not follow the clock enable.");
  // The response is always OKAY.
  resp_okay_a: assert property (!hresp)
    else $error("Error response seen.");
  // Read data stands until the next read is taken.
  rdata_hold_a: assert property (noRead |=> $stable(hrdata))
    else $error("Read data changed without a read.");
  // An event reports the flags that were just set.
  evt_state_a: assert property (evtValid |-> evtState == chanOn)
    else $error("Event state differs from the on flags.");
  // An event is a single-cycle pulse.
  evt_pulse_a: assert property (evtValid |-> onePulse(evtValid))
    else $error("Event pulse longer than one cycle.");
  // A save request is a single-cycle pulse.
  nv_pulse_a: assert property (nvWrite |-> onePulse(nvWrite))
    else $error("Save request longer than one cycle.");
  // A shown message is an active or inactive line.
  msg_kind_a: assert property (msgActive |-> msgKind inside
    {UPB_TXT_ACTIVE, UPB_TXT_INACTIVE})
    else $error("Message shows a label line.");
  // A shown message belongs to an existing channel.
  msg_chan_a: assert property (msgActive |-> msgChannel < UPB_NUM_CH)
    else $error("Message channel out of range.");
endmodule

bind upb_top upb_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk, .resetn, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .chanOn, .chanOff, .chanLed, .nvWrite, .evtValid,
  .evtState, .msgActive, .msgChannel, .msgKind);

/* tb/tb.sv */
/*
  Self-checking bench of the pushbutton block: registers, buttons, flags,
  events, messages, text store and interrupt.
  Assumes the package, carrier, header and checker are compiled first.
*/
`timescale 1ns/1ps
`include "upb_regs.svh"
module tb;
  import upb_pkg::*;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  localparam int TICKS = 4; // Short tick keeps debounce brief.
  logic clk, resetn, ce, hsel, hwrite;
  logic [31:0] haddr, hwdata, rs, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] btnIn, nvLoad, lastChg, lastSt, lastNv, mom, lat, en;
  logic [23:0] m;
  logic [31:0] txt [5];
  upb_taddr_type textRdAddr;
  wire logic hreadyout, hresp, nvWrite, evtValid, msgActive, irq;
  wire logic [31:0] hrdata, textRdData;
  wire logic [11:0] chanOn, chanOff, chanLed, nvData, evtChange, evtState;
  wire logic [3:0] msgChannel;
  wire upb_text_type msgKind;
  int errors = 0;
  int checks = 0;
  // The bus is a single slave, so its ready is the slave's own.
  upb_top #(.TICK_CYCLES(TICKS)) dut (.clk, .resetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .btnIn, .chanOn, .chanOff, .chanLed, .nvLoad,
    .nvData, .nvWrite, .evtValid, .evtChange, .evtState, .msgActive,
    .msgChannel, .msgKind, .textRdAddr, .textRdData, .irq);
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Free-running 100 MHz clock.
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Keep the last reported event and save request for later comparison.
  always @(posedge clk) begin
    if (evtValid === 1'b1) begin
      lastChg <= evtChange;
      lastSt <= evtState;
    end
    if (nvWrite === 1'b1) lastNv <= nvData;
  end
  // Repeatable xorshift source.
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Channels whose two mode bits equal v.
  function logic [11:0] sel(input logic [23:0] md, input logic [1:0] v);
    for (int i = 0; i < 12; i++) sel[i] = (md[2*i+:2] == v);
  endfunction
  // Expected message {shown, kind, channel}; the lowest channel wins.
  function logic [6:0] msgExp(input logic [11:0] up, input logic [11:0] dn);
    msgExp = 7'h00;
    for (int i = 11; i >= 0; i--) begin
      if (up[i]) msgExp = {3'h5, 4'(i)};
      else if (dn[i]) msgExp = {3'h6, 4'(i)};
    end
  endfunction
  // Compare and count.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Wait for the slave's ready under a bound.
  task waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      conclude();
    end
  endtask
  // One single word transfer; read data lands in rd.
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  // Read a register and compare.
  task rdChk(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    check(rd, e);
  endtask
  // Wait under a bound for the on flags to reach e.
  task waitOn(input logic [11:0] e);
    int n;
    n = 0;
    while (chanOn !== e && n < 80) begin
      @(posedge clk);
      n++;
    end
    check(chanOn, e);
    if (n >= 80) conclude();
  endtask
  // Set the buttons, then check flags, event and message.
  task act(input logic [11:0] b, e, up, dn);
    logic [6:0] me;
    logic [11:0] prv;
    @(posedge clk) btnIn <= b;
    prv = chanOn;
    // Nothing is to change: let the debounce settle before looking.
    if (prv === e) repeat (24) @(posedge clk);
    waitOn(e);
    repeat (3) @(posedge clk);
    check(chanOff, en & ~e);
    check(chanLed, e);
    if (prv !== e) check({lastChg, lastSt}, {prv ^ e, e});
    me = msgExp(up, dn);
    check(msgActive, me[6]);
    if (me[6]) check({msgKind, msgChannel}, me[5:0]);
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, btnIn, textRdAddr, en} = '0;
    hsize = 3'h2;
    ce = 1;
    rs = 32'h4420;
    rd = rnd();
    nvLoad = rd[11:0] | 12'h001;
    resetn = 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    rdChk(`UPB_OFF_MODE, 0);
    rdChk(`UPB_OFF_FLASH, 32'h3e8);
    rdChk(`UPB_OFF_DROP + 12'h02c, 0);
    bus(1, 12'h030, 32'hffffffff);
    rdChk(12'h030, 0);
    $display("test reset done");
    act(12'hfff, 0, 0, 0);
    act(0, 0, 0, 0);
    bus(1, `UPB_OFF_MODE, 32'h00aaaaaa);
    waitOn(nvLoad);
    @(posedge clk) btnIn <= 12'hfff;
    repeat (2) @(posedge clk);
    btnIn <= 0;
    repeat (40) @(posedge clk);
    check(chanOn, nvLoad);
    $display("test restore done");
    rdChk(`UPB_OFF_IRQ_STAT, {20'h0, nvLoad});
    check(irq, 0);
    bus(1, `UPB_OFF_IRQ_MASK, 32'hfff);
    repeat (2) @(posedge clk);
    check(irq, 1);
    bus(1, `UPB_OFF_IRQ_STAT, 32'hfff);
    repeat (2) @(posedge clk);
    check(irq, 0);
    $display("test interrupt done");
    bus(1, `UPB_OFF_REPORT, 32'h0fff0fff);
    bus(1, `UPB_OFF_FLASH, 2);
    for (int i = 0; i < 4; i++) begin
      rd = rnd();
      m = (i == 0) ? 24'h555555 : (i == 1) ? 24'haaaaaa : rd[23:0];
      mom = sel(m, 1);
      lat = sel(m, 2);
      en = mom | lat;
      bus(1, `UPB_OFF_MODE, {8'h0, m});
      waitOn(lat & nvLoad);
      act(12'hfff, mom | (lat & ~nvLoad), mom | (lat & ~nvLoad), lat & nvLoad);
      act(0, lat & ~nvLoad, 0, 0);
      check(nvData, nvLoad ^ lat);
      if (lat != 0) check(lastNv, nvLoad ^ lat);
      act(12'hfff, mom | (lat & nvLoad), mom | (lat & nvLoad), lat & ~nvLoad);
      act(0, lat & nvLoad, 0, 0);
    end
    $display("test modes done");
    bus(1, `UPB_OFF_MODE, 1);
    bus(1, `UPB_OFF_DROP, 5);
    waitOn(0);
    @(posedge clk) btnIn <= 1;
    waitOn(1);
    btnIn <= 0;
    repeat (24) @(posedge clk);
    check(chanLed, 1);
    btnIn <= 1;
    repeat (40) @(posedge clk);
    btnIn <= 0;
    repeat (30) @(posedge clk);
    check(chanOn, 1);
    waitOn(0);
    $display("test drop-out done");
    for (int w = 0; w < 5; w++) begin
      txt[w] = rnd();
      bus(1, 12'h900 + 12'(4 * w), txt[w]);
    end
    for (int w = 0; w < 5; w++) begin
      @(posedge clk) textRdAddr <= 9'(64 + w);
      repeat (2) @(posedge clk);
      check(textRdData, txt[w]);
    end
    rdChk(12'h900, 0);
    @(posedge clk) ce <= 0;
    repeat (2) @(posedge clk);
    check(hreadyout, 0);
    ce <= 1;
    $display("test text done");
    conclude();
  end
endmodule
